// ---- logic/drs_cfg.svh ----
// Functional notes
// - reset line is active low request
// - low pulse of 10 us resets; host drives it
// - pulses under 5 us are ignored
// - 5 to 10 us pulses start reset
// - spikes inside valid pulse do not disturb
// - sleep-in reset completes after 5 ms
// - sleep-out reset completes after 120 ms
// - display blanked during reset, then defaults
// - ident byte latched within 5 ms after release
// - host waits 5 ms before commands
// - host waits 120 ms before sleep-out
// - host holds reset 10 us after power-up
// - power loss blanks display within 1 s
// - input filter rejects spikes up to 20 ns
`ifndef DRS_CFG_SVH
`define DRS_CFG_SVH
`define DRS_CLK_MHZ 125
`define DRS_RESET_REJECT_US 5
`define DRS_RESET_ACCEPT_US 10
`define DRS_REST_SLEEP_IN_MS 5
`define DRS_REST_SLEEP_OUT_MS 120
`define DRS_IDENT_LOAD_MS 5
`define DRS_POWER_BLANK_MS 1000
`define DRS_FILTER_NS 20
`define DRS_CLK_NS 8
`define DRS_FILTER_CYC ((`DRS_FILTER_NS + `DRS_CLK_NS - 1) / `DRS_CLK_NS)
`define DRS_REJECT_CYC (`DRS_RESET_REJECT_US * `DRS_CLK_MHZ)
`define DRS_ACCEPT_CYC (`DRS_RESET_ACCEPT_US * `DRS_CLK_MHZ)
`define DRS_US_CYC (`DRS_CLK_MHZ)
`define DRS_MS_CYC (1000 * `DRS_CLK_MHZ)
`endif

// ---- logic/drs_pkg.sv ----
`default_nettype none
package drs_pkg;
    typedef enum logic [2:0] {
        DEV_IDLE = 3'b000,
        DEV_LOW = 3'b001,
        DEV_COMPLETE = 3'b010,
        DEV_READY = 3'b011,
        DEV_DOWN = 3'b100
    } drs_dev_state_type;
    typedef enum logic [1:0] {
        HOST_HOLD = 2'b00,
        HOST_WAIT_CMD = 2'b01,
        HOST_WAIT_SLP = 2'b10,
        HOST_RUN = 2'b11
    } drs_host_state_type;
endpackage
`default_nettype wire

// ---- logic/drs_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface drs_link_if;
    logic reset_line_n;
    logic power_good;
    logic sleep_out_cmd;
    logic cmd_valid;
    modport host (output reset_line_n, output sleep_out_cmd, output cmd_valid, output power_good);
    modport device (input reset_line_n, input sleep_out_cmd, input cmd_valid, input power_good);
endinterface
`default_nettype wire

// ---- logic/drs_device.sv ----
`include "drs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module drs_device #(
    parameter int unsigned MS_CYC = `DRS_MS_CYC,
    parameter int unsigned US_CYC = `DRS_US_CYC,
    parameter logic [7:0] OTP_IDENT = 8'h5a
) (
    input wire logic clk,
    input wire logic rstn,
    drs_link_if.device link,
    output logic display_blank_q,
    output logic logic_reset_q,
    output logic ready_q,
    output logic sleep_out_q,
    output logic [7:0] second_ident_byte_q
);
    localparam int unsigned FILT = `DRS_FILTER_CYC;
    localparam int unsigned REJ = `DRS_RESET_REJECT_US * US_CYC;
    localparam int unsigned ACC = `DRS_RESET_ACCEPT_US * US_CYC;
    localparam int unsigned T_IN = `DRS_REST_SLEEP_IN_MS * MS_CYC;
    localparam int unsigned T_OUT = `DRS_REST_SLEEP_OUT_MS * MS_CYC;
    localparam int unsigned T_PWR = `DRS_POWER_BLANK_MS * MS_CYC;
    localparam int unsigned T_ID = `DRS_IDENT_LOAD_MS * MS_CYC;
    if (US_CYC < 2 || MS_CYC < 2 || REJ >= ACC || FILT > 7) begin : g_bad_timing
        $error("drs_device: bad timing parameters");
    end

    drs_pkg::drs_dev_state_type state_q;
    logic [2:0] flt_cnt_q;
    logic line_q;
    logic [31:0] low_cnt_q;
    logic [31:0] tim_q;
    logic [31:0] pwr_cnt_q;
    logic was_sleep_out_q;
    drs_pkg::drs_dev_state_type resume_q;
    logic low_start;
    logic low_end;
    logic low_valid;
    logic tim_done;
    logic hold_ready;

    // filter: level must persist longer than the spike window
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_q <= 1'b1;
            flt_cnt_q <= 3'h0;
        end else if (link.reset_line_n == line_q) begin
            flt_cnt_q <= 3'h0;
        end else if (flt_cnt_q >= 3'(FILT)) begin
            line_q <= link.reset_line_n;
            flt_cnt_q <= 3'h0;
        end else begin
            flt_cnt_q <= flt_cnt_q + 3'h1;
        end
    end

    // power loss timer: blank within the allowed time
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwr_cnt_q <= 32'h0000_0000;
        end else if (link.power_good) begin
            pwr_cnt_q <= 32'h0000_0000;
        end else if (pwr_cnt_q < T_PWR) begin
            pwr_cnt_q <= pwr_cnt_q + 32'h0000_0001;
        end
    end
    // start and end of a filtered low pulse as the sequencer sees them
    always_comb begin
        low_start = 1'b0;
        low_end = 1'b0;
        if (link.power_good) begin
            low_start = !line_q && (state_q == drs_pkg::DEV_IDLE || state_q == drs_pkg::DEV_READY
                || state_q == drs_pkg::DEV_COMPLETE);
            low_end = line_q && state_q == drs_pkg::DEV_LOW;
        end
    end
    assign low_valid = low_cnt_q >= REJ;
    assign tim_done = (tim_q + 32'h0000_0001) >= (was_sleep_out_q ? T_OUT : T_IN);
    // a pulse still under the reject length leaves a ready device untouched
    assign hold_ready = state_q == drs_pkg::DEV_READY
        || (state_q == drs_pkg::DEV_LOW && !low_valid && resume_q == drs_pkg::DEV_READY);

    // main sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= drs_pkg::DEV_IDLE;
        end else if (!link.power_good) begin
            state_q <= drs_pkg::DEV_DOWN;
        end else begin
            unique case (state_q)
                drs_pkg::DEV_DOWN: begin
                    state_q <= drs_pkg::DEV_IDLE;
                end
                drs_pkg::DEV_IDLE, drs_pkg::DEV_READY: begin
                    if (low_start) begin
                        state_q <= drs_pkg::DEV_LOW;
                    end
                end
                drs_pkg::DEV_LOW: begin
                    if (low_end && !low_valid) begin
                        state_q <= resume_q;
                    end else if (low_end) begin
                        state_q <= drs_pkg::DEV_COMPLETE;
                    end
                end
                drs_pkg::DEV_COMPLETE: begin
                    if (low_start) begin
                        state_q <= drs_pkg::DEV_LOW;
                    end else if (tim_done) begin
                        state_q <= drs_pkg::DEV_READY;
                    end
                end
                default: begin
                    state_q <= drs_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    // state to go back to when a pulse is rejected
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            resume_q <= drs_pkg::DEV_IDLE;
        end else if (low_start) begin
            resume_q <= state_q;
        end
    end

    // filtered low length, saturating at the full pulse width
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_q <= 32'h0000_0000;
        end else if (!link.power_good) begin
            low_cnt_q <= 32'h0000_0000;
        end else if (low_start) begin
            low_cnt_q <= 32'h0000_0001;
        end else if (state_q == drs_pkg::DEV_LOW && !line_q && low_cnt_q < ACC) begin
            low_cnt_q <= low_cnt_q + 32'h0000_0001;
        end
    end

    // reset-complete interval timer, paused while a new pulse is judged
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tim_q <= 32'h0000_0000;
        end else if (low_end && low_valid) begin
            tim_q <= 32'h0000_0000;
        end else if (link.power_good && state_q == drs_pkg::DEV_COMPLETE && !low_start && !tim_done) begin
            tim_q <= tim_q + 32'h0000_0001;
        end
    end

    // sleep state when a pulse began outside the complete interval picks the interval
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            was_sleep_out_q <= 1'b0;
        end else if (low_start && state_q != drs_pkg::DEV_COMPLETE) begin
            was_sleep_out_q <= sleep_out_q;
        end
    end

    // blank while resetting or without power
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            display_blank_q <= 1'b1;
        end else begin
            display_blank_q <= !hold_ready || (pwr_cnt_q != 32'h0000_0000);
        end
    end

    // internal logic held in reset once the pulse counts
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            logic_reset_q <= 1'b1;
        end else begin
            logic_reset_q <= (state_q == drs_pkg::DEV_LOW && low_valid)
                || state_q == drs_pkg::DEV_COMPLETE || state_q == drs_pkg::DEV_DOWN;
        end
    end

    // reset complete flag
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= hold_ready;
        end
    end

    // sleep state tracking, sleep-in after any reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sleep_out_q <= 1'b0;
        end else if (state_q == drs_pkg::DEV_COMPLETE || state_q == drs_pkg::DEV_DOWN) begin
            sleep_out_q <= 1'b0;
        end else if (state_q == drs_pkg::DEV_READY && link.cmd_valid && link.sleep_out_cmd) begin
            sleep_out_q <= 1'b1;
        end
    end

    // ident byte cleared in reset, latched at start of complete interval
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            second_ident_byte_q <= 8'h00;
        end else if (state_q == drs_pkg::DEV_LOW && low_valid) begin
            second_ident_byte_q <= 8'h00;
        end else if (state_q == drs_pkg::DEV_COMPLETE && tim_q < T_ID) begin
            second_ident_byte_q <= OTP_IDENT;
        end
    end
endmodule
`default_nettype wire

// ---- logic/drs_host.sv ----
`include "drs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module drs_host #(
    parameter int unsigned MS_CYC = `DRS_MS_CYC,
    parameter int unsigned US_CYC = `DRS_US_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    drs_link_if.host link,
    input wire logic power_ok,
    input wire logic reset_req,
    input wire logic sleep_out_req,
    output logic cmd_ok_q,
    output logic sleep_out_ok_q,
    output logic power_good_q
);
    localparam int unsigned T_HOLD = `DRS_RESET_ACCEPT_US * US_CYC;
    localparam int unsigned T_CMD = `DRS_REST_SLEEP_IN_MS * MS_CYC;
    localparam int unsigned T_SLP = `DRS_REST_SLEEP_OUT_MS * MS_CYC;
    if (US_CYC < 1 || MS_CYC < 1 || T_CMD >= T_SLP) begin : g_bad_timing
        $error("drs_host: bad timing parameters");
    end
    drs_pkg::drs_host_state_type state_q;
    logic [31:0] cnt_q;
    logic rst_n_q;
    logic sl_q;
    logic cv_q;
    assign link.reset_line_n = rst_n_q;
    assign link.sleep_out_cmd = sl_q;
    assign link.cmd_valid = cv_q;
    assign link.power_good = power_good_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            power_good_q <= 1'b0;
        end else begin
            power_good_q <= power_ok;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= drs_pkg::HOST_HOLD;
            cnt_q <= 32'h0000_0000;
            rst_n_q <= 1'b0;
        end else if (!power_good_q || reset_req) begin
            state_q <= drs_pkg::HOST_HOLD;
            cnt_q <= 32'h0000_0000;
            rst_n_q <= 1'b0;
        end else begin
            unique case (state_q)
                drs_pkg::HOST_HOLD: begin
                    if (cnt_q + 32'h0000_0001 >= T_HOLD) begin
                        rst_n_q <= 1'b1;
                        cnt_q <= 32'h0000_0000;
                        state_q <= drs_pkg::HOST_WAIT_CMD;
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                drs_pkg::HOST_WAIT_CMD: begin
                    cnt_q <= cnt_q + 32'h0000_0001;
                    if (cnt_q + 32'h0000_0001 >= T_CMD) begin
                        state_q <= drs_pkg::HOST_WAIT_SLP;
                    end
                end
                drs_pkg::HOST_WAIT_SLP: begin
                    cnt_q <= cnt_q + 32'h0000_0001;
                    if (cnt_q + 32'h0000_0001 >= T_SLP) begin
                        state_q <= drs_pkg::HOST_RUN;
                    end
                end
                drs_pkg::HOST_RUN: begin
                end
            endcase
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_ok_q <= 1'b0;
            sleep_out_ok_q <= 1'b0;
            sl_q <= 1'b0;
            cv_q <= 1'b0;
        end else begin
            cmd_ok_q <= (state_q == drs_pkg::HOST_WAIT_SLP || state_q == drs_pkg::HOST_RUN) && power_good_q;
            sleep_out_ok_q <= (state_q == drs_pkg::HOST_RUN) && power_good_q;
            cv_q <= sleep_out_req && state_q == drs_pkg::HOST_RUN && power_good_q && !reset_req;
            sl_q <= sleep_out_req && state_q == drs_pkg::HOST_RUN && power_good_q && !reset_req;
        end
    end
endmodule
`default_nettype wire

// ---- test/drs_link_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module drs_link_properties #(
    parameter int unsigned MS_CYC = 20,
    parameter int unsigned US_CYC = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reset_line_n,
    input wire logic power_good,
    input wire logic sleep_out_cmd,
    input wire logic cmd_valid
);
    logic [15:0] lo_q;
    logic [15:0] hi_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lo_q <= 16'h0000;
            hi_q <= 16'h0000;
        end else begin
            lo_q <= reset_line_n ? 16'h0000 : lo_q + 16'h0001;
            hi_q <= !reset_line_n ? 16'h0000 : (&hi_q ? hi_q : hi_q + 16'h0001);
        end
    end
    property p_pair;
        sleep_out_cmd |-> cmd_valid;
    endproperty
    a_pair: assert property (p_pair) else $error("sleep cmd without valid");
    property p_pulse;
        cmd_valid |=> !cmd_valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("cmd longer than one cycle");
    property p_width;
        $rose(reset_line_n) |-> lo_q >= 10 * US_CYC;
    endproperty
    a_width: assert property (p_width) else $error("reset pulse too short");
    property p_cmd;
        cmd_valid |-> hi_q >= 5 * MS_CYC;
    endproperty
    a_cmd: assert property (p_cmd) else $error("cmd too early");
    property p_slp;
        sleep_out_cmd |-> hi_q >= 120 * MS_CYC;
    endproperty
    a_slp: assert property (p_slp) else $error("sleep out too early");
    property p_low;
        !reset_line_n |-> !cmd_valid;
    endproperty
    a_low: assert property (p_low) else $error("cmd during reset");
    property p_fell;
        $fell(reset_line_n) |=> !reset_line_n [*8];
    endproperty
    a_fell: assert property (p_fell) else $error("reset low run short");
    property p_boot;
        !$past(rstn) |-> !reset_line_n && !power_good;
    endproperty
    a_boot: assert property (p_boot) else $error("reset not held at start");
endmodule
`default_nettype wire

// ---- test/display_reset_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module display_reset_sequencer_tb_top;
    localparam int unsigned MS = 20;
    localparam int unsigned US = 2;
    localparam logic [7:0] IDENT = 8'h3c; // arbitrary
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic power_ok = 1'b0;
    logic reset_req = 1'b0;
    logic sleep_out_req = 1'b0;
    logic cmd_ok, slp_ok, pg, blank_a, lrst_a, rdy_a, so_a, blank_b, lrst_b, rdy_b, so_b;
    logic [7:0] id_a, id_b;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n, len;
    int lens[8] = '{2, 9, 0, 0, 0, 10, 15, 40};
    logic [31:0] lfsr_q = 32'h0000_7ea9;
    drs_link_if link_a ();
    drs_link_if link_b ();
    always #4 clk = ~clk;
    drs_host #(.MS_CYC(MS), .US_CYC(US)) drs_host_i (.clk(clk), .rstn(rstn), .link(link_a), .power_ok(power_ok),
        .reset_req(reset_req), .sleep_out_req(sleep_out_req), .cmd_ok_q(cmd_ok), .sleep_out_ok_q(slp_ok),
        .power_good_q(pg));
    drs_device #(.MS_CYC(MS), .US_CYC(US), .OTP_IDENT(IDENT)) drs_device_i (.clk(clk), .rstn(rstn),
        .link(link_a), .display_blank_q(blank_a), .logic_reset_q(lrst_a), .ready_q(rdy_a), .sleep_out_q(so_a),
        .second_ident_byte_q(id_a));
    drs_device #(.MS_CYC(MS), .US_CYC(US), .OTP_IDENT(IDENT)) drs_device_b_i (.clk(clk), .rstn(rstn),
        .link(link_b), .display_blank_q(blank_b), .logic_reset_q(lrst_b), .ready_q(rdy_b), .sleep_out_q(so_b),
        .second_ident_byte_q(id_b));
    drs_link_properties #(.MS_CYC(MS), .US_CYC(US)) drs_link_properties_i (.clk(clk), .rstn(rstn),
        .reset_line_n(link_a.reset_line_n), .power_good(link_a.power_good),
        .sleep_out_cmd(link_a.sleep_out_cmd), .cmd_valid(link_a.cmd_valid));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic resets(input int k);
        return k >= 5 * US;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_rdy(input logic b);
        n = 0;
        while (((b ? rdy_b : rdy_a) !== 1'b1) && n < 3000) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        link_b.reset_line_n = 1'b0;
        link_b.power_good = 1'b1;
        link_b.sleep_out_cmd = 1'b0;
        link_b.cmd_valid = 1'b0;
        cyc(4);
        rstn = 1'b1;
        power_ok = 1'b1;
        cyc(10 * US);
        link_b.reset_line_n = 1'b1;
        wait (link_a.reset_line_n === 1'b1);
        cyc(0);
        wait_rdy(1'b0);
        chk("rdy_in", 1, n >= 5 * MS && n <= 5 * MS + 15);
        chk("blank", 0, blank_a);
        chk("ident", IDENT, id_a);
        chk("sleep", 0, so_a);
        wait (slp_ok === 1'b1);
        cyc(0);
        chk("cmd_ok", 1, cmd_ok);
        chk("pg", 1, pg);
        sleep_out_req = 1'b1;
        cyc(1);
        sleep_out_req = 1'b0;
        cyc(8);
        chk("sleep", 1, so_a);
        reset_req = 1'b1;
        cyc(20);
        chk("lrst", 1, lrst_a);
        chk("blank", 1, blank_a);
        chk("ident_clr", 0, id_a);
        reset_req = 1'b0;
        wait (link_a.reset_line_n === 1'b1);
        cyc(0);
        wait_rdy(1'b0);
        chk("rdy_out", 1, n >= 120 * MS && n <= 120 * MS + 15);
        chk("sleep", 0, so_a);
        for (int i = 0; i < 8; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            len = (lens[i] == 0) ? int'(lfsr_q[2:0]) + 1 : lens[i];
            link_b.reset_line_n = 1'b0;
            cyc(len);
            link_b.reset_line_n = 1'b1;
            cyc(8);
            chk("pulse", !resets(len), rdy_b);
            wait_rdy(1'b1);
            chk("rdy_b", 1, resets(len) ? n + 8 >= 5 * MS && n + 8 <= 5 * MS + 15 : n == 0);
            chk("ident_b", IDENT, id_b);
            chk("lrst_b", 0, lrst_b);
            chk("sleep_b", 0, so_b);
        end
        link_b.reset_line_n = 1'b0;
        cyc(6);
        link_b.reset_line_n = 1'b1;
        cyc(2);
        link_b.reset_line_n = 1'b0;
        cyc(6);
        link_b.reset_line_n = 1'b1;
        cyc(8);
        chk("glitch", 0, rdy_b);
        wait_rdy(1'b1);
        link_b.power_good = 1'b0;
        cyc(4);
        chk("pwr_blank", 1, blank_b);
        print_verdict();
    end
endmodule
`default_nettype wire
